// ===== hw/event_ctrl_consts.svh
// Constants for the two-stage event controller: register addresses, reset
// values, event positions and default level mapping.
// Assumes inclusion by bare name from the package and the design file.
`ifndef EVENT_CTRL_CONSTS_SVH
`define EVENT_CTRL_CONSTS_SVH

// ----------------------------------------------------------------------
// Register addresses on the core register port
// ----------------------------------------------------------------------
`define ADDR_CORE_LATCH 3'h0
`define ADDR_CORE_MASK 3'h1
`define ADDR_CORE_PENDING 3'h2
`define ADDR_SYS_MASK 3'h3
`define ADDR_SYS_STATUS 3'h4
`define ADDR_SYS_WAKEUP 3'h5
`define ADDR_ASSIGN 3'h6
`define ADDR_GLOBAL 3'h7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_WORD 32'h0000_0000
`define RST_GLOBAL_EN 1'h0

// ----------------------------------------------------------------------
// Event positions, 0 highest priority
// ----------------------------------------------------------------------
`define EV_EMU 5'h00
`define EV_RST 5'h01
`define EV_NMI 5'h02
`define EV_EXC 5'h03
`define EV_HWERR 5'h05
`define EV_TMR 5'h06
`define EV_GEN_LO 5'h07
`define EV_GEN_HI 5'h0f
`define EV_NONE 5'h1f
`define GEN_MASK 32'h0000_ff80

// ----------------------------------------------------------------------
// Default level per source: 0..14 level 7, 15..16 level 8, 17..24 level 9,
// 25..27 level 10, 28..29 level 11, 30 level 12, 31 level 13; 32 sources: 15 err, 2 rtc/ppi, 8 sport, 3 spi/uart
// ----------------------------------------------------------------------
`define SRC_LVL8_FIRST 6'h0f
`define SRC_LVL9_FIRST 6'h11
`define SRC_LVL10_FIRST 6'h19
`define SRC_LVL11_FIRST 6'h1c
`define SRC_LVL12_FIRST 6'h1e
`define SRC_LVL13_FIRST 6'h1f
`define LVL_7 4'h7
`define LVL_8 4'h8
`define LVL_9 4'h9
`define LVL_10 4'ha
`define LVL_11 4'hb
`define LVL_12 4'hc
`define LVL_13 4'hd

`endif

// ===== hw/event_ctrl_pkg.sv
// Types shared by the two-stage event controller.
// Assumes the constants header sits beside this file.
`include "event_ctrl_consts.svh"

package event_ctrl_pkg;
    typedef logic [31:0] word_t;
    typedef logic [2:0] reg_addr_t;
    typedef logic [3:0] level_t;
    typedef logic [4:0] event_idx_t;
    // Dispatch sequencer states, one-hot
    typedef enum logic [1:0]
    {
        IDLE_ST = 2'b01,
        ISSUE_ST = 2'b10
    } disp_state_t;
endpackage

// ===== hw/event_ctrl.sv
// Two-stage event controller: system stage routes 32 peripheral sources onto
// nine general levels; core stage latches, masks, prioritises and nests.
// Assumes a supervisor-qualified register port from the core and level
// inputs synchronous to mclk except the source and nmi pins.
`timescale 1ns/1ns
`include "event_ctrl_consts.svh"

// Function
// - Nine general levels 7-15 plus dedicated events
// - Fixed priority, event 0 highest
// - Programmable source-to-level assignment registers
// - Default source mapping onto levels 7-13
// - Latch bit set on event, auto-cleared on acceptance
// - Latch clear only supervisor, only masked events
// - Core mask bit gates servicing
// - Global enable/disable of general levels
// - Pending register tracks active/nested events
// - Core registers are 32 bits wide
// - System mask, status, wakeup 32 bits
// - System mask bit gates peripheral event
// - Status bit mirrors peripheral request level
// - Enabled source wakes idle core
// - Shared levels tolerate simultaneous pulses
// - Pending bit acts as system acknowledgement
// - Rising edge detected in two cycles
// - Latch clears when pending sets
// - Next edge queued once pending set
// - At least three cycles edge to pending
// - Nesting; higher priority preempts lower
// - Nonmaskable from watchdog or external pin
module event_ctrl
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire event_ctrl_pkg::word_t src_irq,
    input wire logic emu_req,
    input wire logic exc_req,
    input wire logic hwerr_req,
    input wire logic tmr_req,
    input wire logic nmi_pin,
    input wire logic wdog_nmi,
    input wire logic soft_raise,
    input wire event_ctrl_pkg::event_idx_t soft_level,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic supervisor,
    input wire event_ctrl_pkg::reg_addr_t reg_addr,
    input wire event_ctrl_pkg::word_t reg_wdata,
    input wire logic global_en_instr,
    input wire logic global_dis_instr,
    input wire logic event_return,
    input wire logic core_idle,
    output event_ctrl_pkg::word_t reg_rdata,
    output logic event_take,
    output event_ctrl_pkg::event_idx_t event_id,
    output logic wake_core
);
    import event_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed
    {
        word_t s1;           // Source pin synchroniser stages
        word_t s2;
        word_t s3;
        word_t sstat;        // Filtered source levels
        logic [2:0] n1;      // NMI pin/emu/exc... synchroniser, nmi only
        word_t gen_d1;       // General level edge detector stages
        word_t gen_d2;
        word_t latch;
        word_t mask;
        word_t pend;
        word_t smask;
        word_t swake;
        logic [127:0] assign_lvl; // 4 bits per source
        logic [4:0] asg_ptr; // Assignment write pointer
        logic glob_en;
        disp_state_t st;
        event_idx_t sel;
        word_t rdata;
        logic take;
        event_idx_t id;
        logic wake;
    } state_t;

    state_t cur_reg;
    state_t cur_next;

    // Default level of one source
    function automatic level_t dflt_level(input int unsigned i);
        level_t l;
        l = `LVL_7;
        if (i >= `SRC_LVL8_FIRST) l = `LVL_8;
        if (i >= `SRC_LVL9_FIRST) l = `LVL_9;
        if (i >= `SRC_LVL10_FIRST) l = `LVL_10;
        if (i >= `SRC_LVL11_FIRST) l = `LVL_11;
        if (i >= `SRC_LVL12_FIRST) l = `LVL_12;
        if (i >= `SRC_LVL13_FIRST) l = `LVL_13;
        return l;
    endfunction

    // Whole default table as a constant, so the async reset loads only constants
    function automatic logic [127:0] dflt_all();
        logic [127:0] v;
        v = '0;
        for (int i = 0; i < 32; i++)
            v[i*4 +: 4] = dflt_level(i);
        return v;
    endfunction

    localparam logic [127:0] dflt_assign = dflt_all();

    // ------------------------------------------------------------------
    // System stage routing
    // ------------------------------------------------------------------
    word_t gen_in;
    genvar gi;
    generate
        // OR of unmasked sources per level; several at once just merge
        for (gi = 0; gi < 32; gi++)
        begin : g_lvl
            logic hit;
            always_comb
            begin
                hit = 1'b0;
                for (int s = 0; s < 32; s++)
                begin
                    if (cur_reg.sstat[s] && cur_reg.smask[s] &&
                        cur_reg.assign_lvl[s*4 +: 4] == 4'(gi) &&
                        gi >= `EV_GEN_LO && gi <= `EV_GEN_HI)
                        hit = 1'b1;
                end
            end
            assign gen_in[gi] = hit;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    word_t raw_ev;
    word_t cand;
    word_t taken;
    event_idx_t best;
    event_idx_t top_pend;
    logic found;

    always_comb
    begin
        cur_next = cur_reg;
        // Dispatch strobe is a one-cycle pulse unless reissued
        cur_next.take = 1'b0;
        taken = `RST_WORD;
        // Source synchroniser: accept change when stages 2 and 3 agree
        cur_next.s1 = src_irq;
        cur_next.s2 = cur_reg.s1;
        cur_next.s3 = cur_reg.s2;
        for (int i = 0; i < 32; i++)
        begin
            if (cur_reg.s2[i] == cur_reg.s3[i])
                cur_next.sstat[i] = cur_reg.s3[i];
        end
        // NMI pin synchroniser; counts high once stages two and three agree
        cur_next.n1 = {cur_reg.n1[1:0], nmi_pin};
        // Two-cycle rising edge detection on general levels
        cur_next.gen_d1 = gen_in;
        cur_next.gen_d2 = cur_reg.gen_d1;
        raw_ev = cur_reg.gen_d1 & ~cur_reg.gen_d2 & `GEN_MASK;
        raw_ev[`EV_EMU] = emu_req;
        raw_ev[`EV_EXC] = exc_req;
        raw_ev[`EV_HWERR] = hwerr_req;
        raw_ev[`EV_TMR] = tmr_req;
        raw_ev[`EV_NMI] = (cur_reg.n1[1] & cur_reg.n1[2]) | wdog_nmi;
        if (soft_raise && soft_level >= `EV_GEN_LO && soft_level <= `EV_GEN_HI)
            raw_ev[soft_level] = 1'b1;
        // Highest-priority unmasked latched event
        cand = cur_reg.latch & cur_reg.mask;
        cand[`EV_EMU] = cur_reg.latch[`EV_EMU];
        cand[`EV_NMI] = cur_reg.latch[`EV_NMI];
        cand[`EV_EXC] = cur_reg.latch[`EV_EXC];
        if (!cur_reg.glob_en)
            cand = cand & ~`GEN_MASK;
        best = `EV_NONE;
        found = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            if (cand[i])
            begin
                best = 5'(i);
                found = 1'b1;
            end
        end
        // Highest-priority pending event gates dispatch and is ended by a return
        top_pend = `EV_NONE;
        for (int i = 15; i >= 0; i--)
        begin
            if (cur_reg.pend[i])
                top_pend = 5'(i);
        end
        // Dispatch sequencer: pick then issue, one event per two cycles
        case (cur_reg.st)
            IDLE_ST:
            begin
                if (found && best < top_pend)
                begin
                    cur_next.sel = best;
                    cur_next.st = ISSUE_ST;
                end
            end
            ISSUE_ST:
            begin
                taken[cur_reg.sel] = 1'b1;
                cur_next.take = 1'b1;
                cur_next.id = cur_reg.sel;
                cur_next.st = IDLE_ST;
            end
            default: cur_next.st = IDLE_ST;
        endcase
        // Pending: set on acceptance; a return ends the innermost handler,
        // which is always the highest-priority pending event
        cur_next.pend = cur_reg.pend | taken;
        if (event_return && top_pend != `EV_NONE)
            cur_next.pend[top_pend] = 1'b0;
        // Latch: clear on acceptance, set wins so next edge is queued
        cur_next.latch = cur_reg.latch & ~taken;
        if (reg_wr && supervisor && reg_addr == `ADDR_CORE_LATCH)
            cur_next.latch = cur_next.latch & (reg_wdata | cur_reg.mask);
        // New events OR in last, so an edge in the clearing cycle survives
        cur_next.latch = cur_next.latch | raw_ev;
        // Global enable instructions
        if (global_en_instr)
            cur_next.glob_en = 1'b1;
        else if (global_dis_instr)
            cur_next.glob_en = 1'b0;
        // Register writes, supervisor only
        if (reg_wr && supervisor)
        begin
            case (reg_addr)
                `ADDR_CORE_MASK: cur_next.mask = reg_wdata;
                `ADDR_SYS_MASK: cur_next.smask = reg_wdata;
                `ADDR_SYS_WAKEUP: cur_next.swake = reg_wdata;
                `ADDR_ASSIGN:
                begin
                    // Data [3:0] is the level for the source in [12:8]
                    cur_next.assign_lvl[reg_wdata[12:8]*4 +: 4] = reg_wdata[3:0];
                    cur_next.asg_ptr = reg_wdata[12:8];
                end
                default: ;
            endcase
        end
        // Register reads, supervisor only; others read zero
        cur_next.rdata = `RST_WORD;
        if (reg_rd && supervisor)
        begin
            case (reg_addr)
                `ADDR_CORE_LATCH: cur_next.rdata = cur_reg.latch;
                `ADDR_CORE_MASK: cur_next.rdata = cur_reg.mask;
                `ADDR_CORE_PENDING: cur_next.rdata = cur_reg.pend;
                `ADDR_SYS_MASK: cur_next.rdata = cur_reg.smask;
                `ADDR_SYS_STATUS: cur_next.rdata = cur_reg.sstat;
                `ADDR_SYS_WAKEUP: cur_next.rdata = cur_reg.swake;
                `ADDR_ASSIGN: cur_next.rdata = {27'(0),
                    cur_reg.assign_lvl[cur_reg.asg_ptr*4 +: 4] == 4'h0 ? 1'b0 : 1'b1,
                    cur_reg.assign_lvl[cur_reg.asg_ptr*4 +: 4]};
                `ADDR_GLOBAL: cur_next.rdata = {31'(0), cur_reg.glob_en};
                default: cur_next.rdata = `RST_WORD;
            endcase
        end
        // Wake-up: enabled source active while core idles
        cur_next.wake = core_idle && |(cur_reg.sstat & cur_reg.swake);
    end

    // ------------------------------------------------------------------
    // State register; async reset to idle with no event pending
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Everything clears except the assignment table and idle codes
            cur_reg <= '0;
            cur_reg.assign_lvl <= dflt_assign;
            cur_reg.st <= IDLE_ST;
            cur_reg.sel <= `EV_NONE;
            cur_reg.id <= `EV_NONE;
            cur_reg.glob_en <= `RST_GLOBAL_EN;
        end
        else
        begin
            cur_reg <= cur_next;
        end
    end

    assign reg_rdata = cur_reg.rdata;
    assign event_take = cur_reg.take;
    assign event_id = cur_reg.id;
    assign wake_core = cur_reg.wake;
endmodule // event_ctrl

// ===== verif/event_ctrl_asserts.sv
// Port assertions for the event controller.
// Assumes it is bound to every event_ctrl instance.
`timescale 1ns/1ns
module event_ctrl_asserts
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire event_ctrl_pkg::word_t src_irq,
    input wire logic emu_req,
    input wire logic wdog_nmi,
    input wire logic soft_raise,
    input wire event_ctrl_pkg::event_idx_t soft_level,
    input wire logic reg_rd,
    input wire logic supervisor,
    input wire logic core_idle,
    input wire event_ctrl_pkg::word_t reg_rdata,
    input wire logic event_take,
    input wire event_ctrl_pkg::event_idx_t event_id,
    input wire logic wake_core
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_idle_rdata: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000) else $error("rdata not zero when idle");
    chk_user_read: assert property (
        reg_rd && !supervisor |=> reg_rdata == 32'h0000_0000) else $error("user read leaked");
    chk_take_pulse: assert property (
        event_take |=> !event_take) else $error("dispatch held two cycles");
    chk_take_legal: assert property (
        event_take |-> event_id <= 5'h0f && event_id != 5'h04) else $error("bad event id");
    chk_soft_delay: assert property (
        soft_raise |=> !(event_take && event_id == $past(soft_level))
        ##1 !(event_take && event_id == $past(soft_level, 2))) else $error("soft too early");
    chk_src_delay: assert property (
        src_irq != 32'h0000_0000 && $past(src_irq) == 32'h0000_0000
        |-> !event_take [*3]) else $error("source dispatched too early");
    chk_emu_first: assert property (
        emu_req |-> ##[1:8] event_take && event_id == 5'h00) else $error("emulation missed");
    chk_wdog_nmi: assert property (
        wdog_nmi |-> ##[1:8] event_take && event_id == 5'h02) else $error("watchdog nmi missed");
    chk_wake_idle: assert property (
        $rose(wake_core) |-> $past(core_idle)) else $error("wake while core busy");
    cov_general: cover property (event_take && event_id == 5'h07);
    cov_emu: cover property (event_take && event_id == 5'h00);
    cov_wake: cover property (wake_core);
endmodule // event_ctrl_asserts

bind event_ctrl event_ctrl_asserts i_event_ctrl_asserts
(
    .mclk(mclk),
    .rst_b(rst_b),
    .src_irq(src_irq),
    .emu_req(emu_req),
    .wdog_nmi(wdog_nmi),
    .soft_raise(soft_raise),
    .soft_level(soft_level),
    .reg_rd(reg_rd),
    .supervisor(supervisor),
    .core_idle(core_idle),
    .reg_rdata(reg_rdata),
    .event_take(event_take),
    .event_id(event_id),
    .wake_core(wake_core)
);

// ===== verif/core_pipe_model.sv
// Core pipeline partner: returns from each dispatched handler.
// Assumes one event_take pulse per dispatch on mclk.
`timescale 1ns/1ns
module core_pipe_model
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic event_take,
    input wire logic auto_ret,
    output logic event_return
);
    logic [2:0] cnt_reg;
    // Handler runs four cycles, then one return pulse
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_reg <= 3'h0;
        else if (event_take && auto_ret)
            cnt_reg <= 3'h4;
        else if (cnt_reg != 3'h0)
            cnt_reg <= cnt_reg - 3'h1;
    end
    assign event_return = (cnt_reg == 3'h1);
endmodule // core_pipe_model

// ===== verif/event_ctrl_tb.sv
// Self-checking bench for the event controller.
// Assumes the design, its bound checker and the core pipeline model.
`timescale 1ns/1ns
module event_ctrl_tb;
    import event_ctrl_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    word_t src_irq = '0;
    logic [8:0] ctl = '0;
    event_idx_t lvl = '0;
    logic nmi_pin = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sup = 1'b1;
    reg_addr_t addr = '0;
    word_t wdata = '0;
    logic core_idle = 1'b0;
    logic auto_ret = 1'b1;
    logic model_ret;
    word_t reg_rdata;
    word_t rd_val;
    logic event_take;
    event_idx_t event_id;
    logic wake_core;
    int num_errors = 0;
    int comparisons = 0;
    // Clock at 20 MHz
    always #25 mclk = ~mclk;
    event_ctrl i_event_ctrl
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .src_irq(src_irq),
        .emu_req(ctl[4]),
        .exc_req(ctl[3]),
        .hwerr_req(ctl[2]),
        .tmr_req(ctl[1]),
        .nmi_pin(nmi_pin),
        .wdog_nmi(ctl[0]),
        .soft_raise(ctl[8]),
        .soft_level(lvl),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .supervisor(sup),
        .reg_addr(addr),
        .reg_wdata(wdata),
        .global_en_instr(ctl[5]),
        .global_dis_instr(ctl[6]),
        .event_return(ctl[7] | model_ret),
        .core_idle(core_idle),
        .reg_rdata(reg_rdata),
        .event_take(event_take),
        .event_id(event_id),
        .wake_core(wake_core)
    );
    core_pipe_model i_core_pipe_model
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .event_take(event_take),
        .auto_ret(auto_ret),
        .event_return(model_ret)
    );
    task automatic tick(input int n = 1);
        repeat (n)
        begin
            @(posedge mclk);
            #2;
        end
    endtask
    task automatic check(input string what, input word_t exp, input word_t got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One register access, strobe held one cycle
    task automatic acc(input logic wr, input reg_addr_t a, input word_t d, input logic s = 1);
        tick();
        {reg_wr, reg_rd, addr, wdata, sup} = {wr, !wr, a, d, s};
        tick();
        rd_val = reg_rdata;
        {reg_wr, reg_rd, sup} = 3'h1;
    endtask
    task automatic rdc(input reg_addr_t a, input word_t exp);
        acc(0, a, '0);
        check("register", exp, rd_val);
    endtask
    task automatic pulse(input logic [8:0] v, input event_idx_t l = 5'h0e);
        tick();
        {ctl, lvl} = {v, l};
        tick();
        ctl = '0;
    endtask
    task automatic take(input event_idx_t id);
        int n;
        n = 0;
        while (event_take !== 1'b1 && n < 30)
        begin
            tick();
            n++;
        end
        if (n == 30)
        begin
            num_errors++;
            $display("[FAIL] event_take expected 1 seen 0");
            give_verdict();
        end
        check("event_id", {27'h0, id}, {27'h0, event_id});
    endtask
    task automatic none(input int n);
        repeat (n)
        begin
            tick();
            check("event_take", '0, {31'h0, event_take});
        end
    endtask
    task automatic t_regs;
        for (int a = 0; a < 8; a++)
            if (a != 6)
                rdc(reg_addr_t'(a), '0);
        acc(1, 3'h3, 32'hffff_ffff);
        acc(1, 3'h3, '0, 1'b0);
        rdc(3'h3, 32'hffff_ffff);
        acc(0, 3'h3, '0, 1'b0);
        check("user read", '0, rd_val);
        acc(1, 3'h1, 32'h0000_ffe0);
        rdc(3'h1, 32'h0000_ffe0);
        acc(1, 3'h2, 32'hffff_ffff);
        rdc(3'h2, '0);
        pulse(9'h020);
        rdc(3'h7, 32'h0000_0001);
    endtask
    task automatic t_route;
        int s[7] = '{0, 15, 17, 25, 28, 30, 31};
        for (int i = 0; i < 7; i++)
        begin
            src_irq[s[i]] = 1'b1;
            take(event_idx_t'(7 + i));
            rdc(3'h4, word_t'(1) << s[i]);
            src_irq = '0;
            tick(6);
        end
        acc(1, 3'h3, 32'hffff_fffd);
        src_irq[1] = 1'b1;
        none(12);
        src_irq = 32'h0000_0005;
        take(5'h07);
        none(12);
        src_irq = '0;
        acc(1, 3'h3, 32'hffff_ffff);
        tick(6);
        acc(1, 3'h6, 32'h0000_000c);
        src_irq[0] = 1'b1;
        take(5'h0c);
        src_irq = '0;
        tick(6);
        acc(1, 3'h6, 32'h0000_0007);
    endtask
    task automatic t_mask;
        acc(1, 3'h1, 32'h0000_bfe0);
        pulse(9'h100);
        none(8);
        rdc(3'h0, 32'h0000_4000);
        acc(1, 3'h0, '0, 1'b0);
        rdc(3'h0, 32'h0000_4000);
        acc(1, 3'h0, '0);
        rdc(3'h0, '0);
        acc(1, 3'h1, 32'h0000_ffe0);
        none(8);
        pulse(9'h100);
        take(5'h0e);
        pulse(9'h040);
        pulse(9'h100, 5'h0f);
        none(8);
        pulse(9'h020);
        take(5'h0f);
    endtask
    task automatic t_nest;
        tick(8);
        auto_ret = 1'b0;
        pulse(9'h100);
        take(5'h0e);
        pulse(9'h100, 5'h0f);
        none(8);
        src_irq[17] = 1'b1;
        take(5'h09);
        rdc(3'h2, 32'h0000_4200);
        pulse(9'h080);
        rdc(3'h2, 32'h0000_4000);
        pulse(9'h080);
        take(5'h0f);
        pulse(9'h080);
        {src_irq, auto_ret} = 33'h1;
        tick(6);
    endtask
    task automatic t_wake;
        acc(1, 3'h5, 32'h8000_0000);
        rdc(3'h5, 32'h8000_0000);
        {core_idle, src_irq} = 33'h1_8000_0000;
        for (int n = 0; n < 20 && wake_core !== 1'b1; n++)
            tick();
        check("wake_core", 32'h1, {31'h0, wake_core});
        {core_idle, src_irq} = '0;
        tick(8);
    endtask
    task automatic t_ded;
        event_idx_t id[5] = '{5'h02, 5'h06, 5'h05, 5'h03, 5'h00};
        for (int i = 0; i < 5; i++)
        begin
            pulse(9'h001 << i);
            take(id[i]);
            tick(6);
        end
        nmi_pin = 1'b1;
        take(5'h02);
        nmi_pin = 1'b0;
    endtask
    task automatic give_verdict;
        if (num_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Reset for ten cycles, then every scenario in turn
    initial
    begin
        tick(10);
        rst_b = 1'b1;
        t_regs();
        t_route();
        t_mask();
        t_nest();
        t_wake();
        t_ded();
        give_verdict();
    end
endmodule // event_ctrl_tb
